// file: common/hr_link_if.sv
`timescale 1ns/1ps
interface hr_link_if #(parameter int NCH = 4);
  logic per_tick;
  logic [1:0] hr_active;
  logic plus8;
  logic [1:0][NCH-1:0] wg;
  logic [1:0][NCH-1:0][1:0] edge_kind;
  logic [1:0][NCH-1:0][2:0] cmp_lo;

  modport dev (
    output per_tick,
    output hr_active,
    output plus8,
    input wg,
    input edge_kind,
    input cmp_lo
  );

  modport tmr (
    input per_tick,
    input hr_active,
    input plus8,
    output wg,
    output edge_kind,
    output cmp_lo
  );
endinterface

// file: common/hr_pkg.sv
package hr_pkg;

  // control register A
  localparam logic [7:0] HR_CTRL_A_OFFSET = 8'h00;
  localparam logic [7:0] HR_CTRL_A_RESET = 8'h00;
  localparam logic [7:0] HR_CTRL_A_WMASK = 8'h07;
  localparam int HR_SEL_LSB = 0;
  localparam int HR_SEL_MSB = 1;
  localparam int HR_PLUS8_BIT = 2;

  // timing: ref_clk is the quad-rate clock
  localparam int HR_REF_CLK_PERIOD_NS = 100;
  localparam int HR_QUAD_RATIO = 4;
  localparam int HR_PER_CLK_PERIOD_NS = HR_REF_CLK_PERIOD_NS * HR_QUAD_RATIO;
  localparam int HR_PHASES = HR_PER_CLK_PERIOD_NS / HR_REF_CLK_PERIOD_NS;
  localparam logic [1:0] HR_PHASE_LAST = 2'(HR_PHASES - 1);
  localparam logic [1:0] HR_PHASE_TICK = 2'(HR_PHASES - 2);

  // counter steps and masks
  localparam logic [15:0] HR_STEP_ONE = 16'h0001;
  localparam logic [15:0] HR_STEP_FOUR = 16'h0004;
  localparam logic [15:0] HR_STEP_EIGHT = 16'h0008;
  localparam logic [15:0] HR_MASK_NONE = 16'hffff;
  localparam logic [15:0] HR_MASK_FOUR = 16'hfffc;
  localparam logic [15:0] HR_MASK_EIGHT = 16'hfff8;

  // kind of the edge that the coarse waveform just made
  localparam logic [1:0] HR_KIND_NONE = 2'h0;
  localparam logic [1:0] HR_KIND_UP = 2'h1;
  localparam logic [1:0] HR_KIND_DOWN = 2'h2;

  typedef enum logic [1:0] {
    HR_MODE_FREQ = 2'h0,
    HR_MODE_SINGLE = 2'h1,
    HR_MODE_DUAL = 2'h2
  } hr_mode_t;

  typedef enum logic [1:0] {
    HR_DIR_UP = 2'h1,
    HR_DIR_DOWN = 2'h2
  } hr_dir_t;

  function automatic logic [1:0] hr_sel_decode(input logic [1:0] sel);
    logic [1:0] en;
    unique case (sel)
      2'h0: en = 2'h0;
      2'h1: en = 2'h1;
      2'h2: en = 2'h2;
      2'h3: en = 2'h3;
    endcase
    return en;
  endfunction

  function automatic logic [15:0] hr_low_mask(input logic act,
                                              input logic plus8);
    return !act ? HR_MASK_NONE : (plus8 ? HR_MASK_EIGHT : HR_MASK_FOUR);
  endfunction

endpackage

// file: test/hr_fine_res_sva.sv
`timescale 1ns/1ps
module hr_fine_res_sva #(
  parameter int NCH = 4
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // register strobe
  input wire logic ctrl_we,
  input wire logic [7:0] ctrl_wdata,
  // link
  input wire logic per_tick,
  input wire logic [1:0] hr_active,
  input wire logic plus8,
  input wire logic [1:0][NCH-1:0] wg,
  input wire logic [1:0][NCH-1:0][1:0] edge_kind
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  logic kind_bad;
  always_comb begin
    kind_bad = 1'b0;
    for (int t = 0; t < 2; t++) begin
      for (int c = 0; c < NCH; c++) begin
        kind_bad = kind_bad | (edge_kind[t][c] == 2'h3);
      end
    end
  end
  property p_tick_period;
    per_tick |=> !per_tick [*3] ##1 per_tick;
  endproperty
  a_tick_period: assert property (p_tick_period)
    else $error("tick spacing wrong");
  property p_wg_at_tick;
    $changed(wg) |-> $past(per_tick);
  endproperty
  a_wg_at_tick: assert property (p_wg_at_tick)
    else $error("waveform moved off tick");
  property p_kind_at_tick;
    $changed(edge_kind) |-> $past(per_tick);
  endproperty
  a_kind_at_tick: assert property (p_kind_at_tick)
    else $error("edge kind moved off tick");
  property p_wg_hold;
    $changed(wg) |=> $stable(wg) [*3];
  endproperty
  a_wg_hold: assert property (p_wg_hold)
    else $error("coarse level held too briefly");
  property p_kind_legal;
    !kind_bad;
  endproperty
  a_kind_legal: assert property (p_kind_legal)
    else $error("illegal edge kind");
  property p_sel_write;
    ctrl_we |=> hr_active == $past(ctrl_wdata[1:0]);
  endproperty
  a_sel_write: assert property (p_sel_write)
    else $error("timer select not decoded");
  property p_plus_write;
    ctrl_we |=> plus8 == $past(ctrl_wdata[2]);
  endproperty
  a_plus_write: assert property (p_plus_write)
    else $error("eightfold bit not taken");
  property p_ctrl_hold;
    !ctrl_we |=> $stable(hr_active) && $stable(plus8);
  endproperty
  a_ctrl_hold: assert property (p_ctrl_hold)
    else $error("control moved without write");
endmodule

// file: test/timer_fine_resolution_extension_tb_top.sv
`timescale 1ns/1ps
module timer_fine_resolution_extension_tb_top;
  import hr_pkg::*;
  localparam int NCH = 4;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic ce = 1'b1;
  logic ctrl_we = 1'b0;
  logic [7:0] ctrl_wdata = 8'h00;
  logic [7:0] ctrl_rdata;
  logic [2*NCH-1:0] pin_first;
  logic [2*NCH-1:0] pin_second;
  logic port_hires;
  logic [1:0] timer_hires;
  logic [1:0] top_evt;
  int ctrl_model[$];
  hr_mode_t mode [2];
  logic [3:0] presc_div [2];
  logic [15:0] period [2];
  logic [15:0] count_rd [2];
  logic [1:0][NCH-1:0][15:0] cmp;
  int fail_count = 0;
  int check_count = 0;
  int seed = 29753;
  int exp_v;
  int hi;
  int odd;
  always #50 ref_clk = ~ref_clk;
  hr_link_if #(.NCH(NCH)) link ();
  hr_fine_res_ext #(.NCH(NCH)) i_hr_fine_res_ext (.ref_clk, .reset, .ce,
    .link(link.dev), .ctrl_we, .ctrl_wdata, .ctrl_rdata, .pin_first,
    .pin_second, .port_hires, .timer_hires);
  hr_timer_wg #(.NCH(NCH)) i_hr_timer_wg (.ref_clk, .reset, .ce,
    .link(link.tmr), .mode, .presc_div, .period, .cmp, .count_rd,
    .top_evt(top_evt));
  hr_fine_res_sva #(.NCH(NCH)) i_hr_fine_res_sva (.ref_clk, .reset,
    .ctrl_we, .ctrl_wdata, .per_tick(link.per_tick),
    .hr_active(link.hr_active), .plus8(link.plus8), .wg(link.wg),
    .edge_kind(link.edge_kind));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] v);
    ctrl_model.push_back(int'(v) & int'(HR_CTRL_A_WMASK));
    @(posedge ref_clk);
    ctrl_we <= 1'b1;
    ctrl_wdata <= v;
    @(posedge ref_clk);
    ctrl_we <= 1'b0;
    @(negedge ref_clk);
    check(16'(ctrl_rdata), 16'(ctrl_model.pop_front()));
  endtask
  // cycles from one top event of timer 0 to the next
  task automatic evt_gap(output int g);
    int i;
    i = 0;
    g = 0;
    while (top_evt[0] !== 1'b1 && i < 600) begin
      @(negedge ref_clk);
      i++;
    end
    do begin
      @(negedge ref_clk);
      g++;
    end while (top_evt[0] !== 1'b1 && g < 600);
  endtask
  // step 0 skips the delta test, for modes that count down
  task automatic cnt_watch(input int step, input logic [15:0] lo);
    logic [15:0] prev_c;
    prev_c = count_rd[0];
    repeat (64) begin
      @(negedge ref_clk);
      check(count_rd[0] & lo, 16'h0000);
      if (step != 0 && count_rd[0] != prev_c && count_rd[0] != 16'h0000)
        check(16'(count_rd[0] - prev_c), 16'(step));
      prev_c = count_rd[0];
    end
  endtask
  task automatic wait_pin(input int k, input logic v);
    int i;
    i = 0;
    while (pin_first[k] !== v) begin
      @(negedge ref_clk);
      i++;
      if (i > 600) begin
        fail_count++;
        final_report();
      end
    end
  endtask
  // pulse ends where the first half drops, halves fall monotonic
  task automatic halves(input int k, output int n);
    n = 0;
    // skip a pulse that may have begun under the old setup
    wait_pin(k, 1'b1);
    wait_pin(k, 1'b0);
    wait_pin(k, 1'b1);
    while (pin_first[k] === 1'b1 && n < 1200) begin
      n += int'(pin_first[k]) + int'(pin_second[k]);
      @(negedge ref_clk);
    end
  endtask
  task automatic win(input int k, output int n, output int o);
    n = 0;
    o = 0;
    repeat (300) begin
      @(negedge ref_clk);
      n += int'(pin_first[k]) + int'(pin_second[k]);
      o += int'(pin_first[k] !== pin_second[k]);
    end
  endtask
  initial begin
    mode[0] <= HR_MODE_SINGLE;
    mode[1] <= HR_MODE_SINGLE;
    presc_div[0] <= 4'h0;
    presc_div[1] <= 4'h0;
    period[0] <= 16'h0080;
    period[1] <= 16'h0080;
    cmp <= '0;
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    @(negedge ref_clk);
    check(16'(ctrl_rdata), 16'(HR_CTRL_A_RESET));
    check(16'(port_hires), 16'h0000);
    // junk in the upper bits must never read back
    for (int v = 0; v < 8; v++) begin
      wr(8'(($random(seed) & 32'hf8) | v));
      check(16'(ctrl_rdata), 16'(v));
      @(negedge ref_clk);
      check(16'(timer_hires), 16'(v & 3));
      check(16'(port_hires), 16'((v & 3) != 0));
    end
    wr(8'h03);
    cnt_watch(4, 16'h0003);
    evt_gap(hi);
    check(16'(hi), 16'(HR_QUAD_RATIO * (int'(period[0]) / 4 + 1)));
    wr(8'h07);
    cnt_watch(8, 16'h0007);
    evt_gap(hi);
    check(16'(hi), 16'(HR_QUAD_RATIO * (int'(period[0]) / 8 + 1)));
    for (int m = 0; m < 3; m++) begin
      @(posedge ref_clk);
      mode[0] <= hr_mode_t'(m);
      cnt_watch(0, 16'h0007);
    end
    @(posedge ref_clk);
    mode[0] <= HR_MODE_SINGLE;
    for (int p = 0; p < 2; p++) begin
      exp_v = 16 + ($random(seed) & 31);
      @(posedge ref_clk);
      cmp[0][0] <= 16'(exp_v);
      wr(p == 1 ? 8'h05 : 8'h01);
      halves(0, hi);
      check(16'(hi), 16'(p == 1 ? exp_v : 2 * exp_v));
    end
    @(posedge ref_clk);
    cmp[1][0] <= 16'(16 + ($random(seed) & 31));
    cmp[0][0] <= 16'h0002;
    wr(8'h01);
    wait_pin(0, 1'b0);
    win(0, hi, odd);
    check(16'(hi), 16'h0000);
    win(NCH, hi, odd);
    check(16'(odd), 16'h0000);
    @(posedge ref_clk);
    reset <= 1'b1;
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    @(negedge ref_clk);
    check(16'(ctrl_rdata), 16'h0000);
    final_report();
  end
endmodule

// file: verilog/hr_edge_place.sv
`timescale 1ns/1ps
module hr_edge_place (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic ce,
  // coarse side
  input wire logic [1:0] phase,
  input wire logic wg_in,
  input wire logic [2:0] delay,
  // placed output, two halves of each ref_clk cycle
  output logic out_first,
  output logic out_second
);
  import hr_pkg::*;

  logic lvl_q;
  logic old_q;
  logic new_q;
  logic [2:0] d_q;
  logic edge_prev_q;
  logic [2:0] last_d_q;
  logic edge_now;
  logic [2:0] d_eff;
  logic old_v;
  logic new_v;
  logic [2:0] d_v;
  logic [3:0] slot;

  assign edge_now = (phase == 2'h0) && (wg_in != lvl_q);

  // stretch a pulse that would end before one peripheral cycle
  always_comb begin
    d_eff = delay;
    if (edge_prev_q && delay < last_d_q) begin
      d_eff = last_d_q;
    end
  end

  always_comb begin
    old_v = (phase == 2'h0) ? lvl_q : old_q;
    new_v = (phase == 2'h0) ? wg_in : new_q;
    d_v = (phase == 2'h0) ? (edge_now ? d_eff : 3'h0) : d_q;
    slot = {1'b0, phase, 1'b0};
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      lvl_q <= 1'b0;
      old_q <= 1'b0;
      new_q <= 1'b0;
      d_q <= 3'h0;
    end else if (ce && phase == 2'h0) begin
      lvl_q <= wg_in;
      old_q <= lvl_q;
      new_q <= wg_in;
      d_q <= d_v;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      edge_prev_q <= 1'b0;
      last_d_q <= 3'h0;
    end else if (ce && phase == 2'h0) begin
      edge_prev_q <= edge_now;
      if (edge_now) begin
        last_d_q <= d_eff;
      end
    end
  end

  // each ref_clk cycle covers two eighths of the peripheral cycle
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      out_first <= 1'b0;
      out_second <= 1'b0;
    end else if (ce) begin
      out_first <= (slot < {1'b0, d_v}) ? old_v : new_v;
      out_second <= ((slot + 4'h1) < {1'b0, d_v}) ? old_v : new_v;
    end
  end
endmodule

// file: verilog/hr_fine_res_ext.sv
`timescale 1ns/1ps
// Function
// - peripheral cycle is four quad-rate clocks
// - timer runs undivided when extension active
// - active timer ignores two lsb, steps four
// - upper 14 bits coarse, low bits here
// - period low bits must be zero
// - count reads zero in low bits
// - low bits never affect timer events
// - eightfold mode resolves three low bits
// - no output pulse under one peripheral cycle
// - works for frequency, single, dual slope
// - control bit 2 selects eightfold resolution
// - select field 00 none, 01, 10, 11
// - nonzero select raises port_hires for the port
// - each timer on a port enabled by its own select bit
// - control bits 7:3 read zero
module hr_fine_res_ext #(
  parameter int NCH = 4
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic ce,
  // link to the timer/counter waveform generators
  hr_link_if.dev link,
  // control register A
  input wire logic ctrl_we,
  input wire logic [7:0] ctrl_wdata,
  output logic [7:0] ctrl_rdata,
  // port pins, level in first and second half of each ref_clk cycle
  output logic [2*NCH-1:0] pin_first,
  output logic [2*NCH-1:0] pin_second,
  // status
  output logic port_hires,
  output logic [1:0] timer_hires
);
  import hr_pkg::*;

  logic [7:0] control_a_q;
  logic [1:0] phase_q;
  logic tick_q;
  logic [1:0] sel_en;
  logic eightfold;
  logic [1:0][NCH-1:0][2:0] fine_d;
  logic [1:0] sel_seen_q;
  logic plus8_seen_q;
  logic [1:0][NCH-1:0][2:0] lo_seen_q;

  // delay in eighths of a peripheral cycle for the edge just made
  function automatic logic [2:0] fine_delay(input logic act,
                                            input logic plus8,
                                            input logic [1:0] kind,
                                            input logic [2:0] lo);
    logic [2:0] unit;
    logic [2:0] d;
    unit = plus8 ? lo : {lo[1:0], 1'b0};
    d = 3'h0;
    if (act) begin
      if (kind == HR_KIND_UP) begin
        d = unit;
      end else if (kind == HR_KIND_DOWN) begin
        d = 3'(4'h8 - {1'b0, unit});
      end
    end
    return d;
  endfunction

  // reserved bits are dropped on write so they always read zero
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      control_a_q <= HR_CTRL_A_RESET;
    end else if (ce && ctrl_we) begin
      control_a_q <= ctrl_wdata & HR_CTRL_A_WMASK;
    end
  end

  assign ctrl_rdata = control_a_q;

  assign sel_en = hr_sel_decode(control_a_q[HR_SEL_MSB:HR_SEL_LSB]);
  assign eightfold = control_a_q[HR_PLUS8_BIT];

  // ref_clk is taken as the quad-rate clock; peripheral cycle = 4 phases
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      phase_q <= 2'h0;
    end else if (ce) begin
      phase_q <= (phase_q == HR_PHASE_LAST) ? 2'h0 : phase_q + 2'h1;
    end
  end

  // tick stands in the last phase so the timer moves into phase 0
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tick_q <= 1'b0;
    end else if (ce) begin
      tick_q <= (phase_q == HR_PHASE_TICK);
    end
  end

  assign link.per_tick = tick_q;
  assign link.hr_active = sel_en;
  assign link.plus8 = eightfold;

  // the timer picks an edge with the setup of the tick edge; keep that
  // setup so a write or compare change on the tick cannot place the
  // edge with a step the timer never used
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sel_seen_q <= 2'h0;
      plus8_seen_q <= 1'b0;
      lo_seen_q <= '0;
    end else if (ce && phase_q == HR_PHASE_LAST) begin
      sel_seen_q <= sel_en;
      plus8_seen_q <= eightfold;
      lo_seen_q <= link.cmp_lo;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      port_hires <= 1'b0;
      timer_hires <= 2'h0;
    end else if (ce) begin
      port_hires <= |sel_en;
      timer_hires <= sel_en;
    end
  end

  always_comb begin
    for (int t = 0; t < 2; t++) begin
      for (int c = 0; c < NCH; c++) begin
        // an unselected timer gets zero delay and passes straight on
        fine_d[t][c] = fine_delay(sel_seen_q[t], plus8_seen_q,
                                  link.edge_kind[t][c], lo_seen_q[t][c]);
      end
    end
  end

  // every pin goes through the same stage, so latency matches across
  // the port whether or not its timer is selected
  for (genvar t = 0; t < 2; t++) begin : g_tmr
    for (genvar c = 0; c < NCH; c++) begin : g_ch
      hr_edge_place u_place (
        .ref_clk(ref_clk),
        .reset(reset),
        .ce(ce),
        .phase(phase_q),
        .wg_in(link.wg[t][c]),
        .delay(fine_d[t][c]),
        .out_first(pin_first[t*NCH+c]),
        .out_second(pin_second[t*NCH+c])
      );
    end
  end
endmodule

// file: verilog/hr_timer_wg.sv
`timescale 1ns/1ps
module hr_timer_wg #(
  parameter int NCH = 4
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic ce,
  // link to the fine-resolution extension
  hr_link_if.tmr link,
  // timer setup, one entry per timer
  input wire hr_pkg::hr_mode_t mode [2],
  input wire logic [3:0] presc_div [2],
  input wire logic [15:0] period [2],
  input wire logic [1:0][NCH-1:0][15:0] cmp,
  // timer status
  output logic [15:0] count_rd [2],
  output logic [1:0] top_evt
);
  import hr_pkg::*;

  for (genvar t = 0; t < 2; t++) begin : g_tmr
    logic [15:0] cnt_q;
    logic [3:0] psc_q;
    hr_dir_t dir_q;
    logic [15:0] mask;
    logic [15:0] step;
    logic [15:0] cm;
    logic advance;
    logic top;
    logic bottom;
    logic [NCH-1:0] wg_q;
    logic [NCH-1:0][1:0] kind_q;

    assign mask = hr_low_mask(link.hr_active[t], link.plus8);
    assign step = !link.hr_active[t] ? HR_STEP_ONE :
                  (link.plus8 ? HR_STEP_EIGHT : HR_STEP_FOUR);
    assign cm = cnt_q & mask;
    assign top = cm == (period[t] & mask);
    assign bottom = cm == 16'h0000;
    // prescaler is bypassed when the extension drives this timer
    assign advance = link.per_tick &&
                     (link.hr_active[t] || psc_q == presc_div[t]);

    always_ff @(posedge ref_clk) begin
      if (reset) begin
        psc_q <= 4'h0;
      end else if (ce && link.per_tick) begin
        psc_q <= advance ? 4'h0 : psc_q + 4'h1;
      end
    end

    always_ff @(posedge ref_clk) begin
      if (reset) begin
        cnt_q <= 16'h0000;
        dir_q <= HR_DIR_UP;
        top_evt[t] <= 1'b0;
      end else if (ce) begin
        top_evt[t] <= 1'b0;
        if (advance) begin
          if (mode[t] != HR_MODE_DUAL) begin
            cnt_q <= top ? 16'h0000 : cm + step;
            top_evt[t] <= top;
          end else if (dir_q == HR_DIR_UP) begin
            dir_q <= top ? HR_DIR_DOWN : HR_DIR_UP;
            cnt_q <= top ? cm - step : cm + step;
          end else begin
            dir_q <= bottom ? HR_DIR_UP : HR_DIR_DOWN;
            cnt_q <= bottom ? cm + step : cm - step;
            top_evt[t] <= bottom;
          end
        end
      end
    end

    assign count_rd[t] = cnt_q & mask;

    for (genvar c = 0; c < NCH; c++) begin : g_ch
      logic match;
      assign match = cm == (cmp[t][c] & mask);
      assign link.cmp_lo[t][c] = cmp[t][c][2:0];

      always_ff @(posedge ref_clk) begin
        if (reset) begin
          wg_q[c] <= 1'b0;
          kind_q[c] <= HR_KIND_NONE;
        end else if (ce && advance) begin
          unique case (mode[t])
            HR_MODE_FREQ: begin
              if (top) begin
                wg_q[c] <= ~wg_q[c];
                kind_q[c] <= HR_KIND_NONE;
              end
            end
            HR_MODE_SINGLE: begin
              // clear wins over set, so a compare below one step is dark
              if (match) begin
                wg_q[c] <= 1'b0;
                kind_q[c] <= HR_KIND_UP;
              end else if (bottom) begin
                wg_q[c] <= 1'b1;
                kind_q[c] <= HR_KIND_NONE;
              end
            end
            HR_MODE_DUAL: begin
              if (match) begin
                wg_q[c] <= (dir_q == HR_DIR_DOWN);
                kind_q[c] <= (dir_q == HR_DIR_UP) ? HR_KIND_UP
                                                   : HR_KIND_DOWN;
              end
            end
            default: begin
              wg_q[c] <= 1'b0;
              kind_q[c] <= HR_KIND_NONE;
            end
          endcase
        end
      end
    end

    assign link.wg[t] = wg_q;
    assign link.edge_kind[t] = kind_q;
  end
endmodule
